// >>> include/dshp_pkg.sv
package dshp_pkg;
	// host strobe timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int SETUP_NS = 30;
	localparam int STROBE_NS = 100;
	localparam int HOLD_NS = 30;
	localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// device register model
	localparam logic [2:0] MODEM_CTRL_OFS = 3'h4;
	localparam int IRQ_OUTPUT_ENABLE_BIT = 3;
	localparam logic [7:0] REG_RESET = 8'h00;
	// build option for the force pin
	localparam logic [1:0] FORCE_PIN = 2'h0;
	localparam logic [1:0] FORCE_HIGH = 2'h1;
	localparam logic [1:0] FORCE_LOW = 2'h2;
	// host apb map
	localparam logic [11:0] CMD_OFS = 12'h000;
	localparam logic [11:0] STATUS_OFS = 12'h004;
	localparam logic [11:0] CONFIG_OFS = 12'h008;
	localparam logic [11:0] IRQ_STATUS_OFS = 12'h00c;
	localparam logic [11:0] IRQ_CLEAR_OFS = 12'h010;
	localparam logic [11:0] IRQ_ENABLE_OFS = 12'h014;
	localparam int CMD_START_BIT = 0;
	localparam int CMD_READ_BIT = 1;
	localparam int CMD_ADDR_LSB = 2;
	localparam int CMD_CHAN_LSB = 5;
	localparam int CMD_DATA_LSB = 8;
	localparam int CFG_STYLE_BIT = 0;
	localparam int CFG_FORCE_BIT = 1;
	localparam logic CFG_STYLE_RESET = 1'b1;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_CHAN_LSB = 1;
	localparam int IRQ_REFUSED_BIT = 5;
	localparam int IRQ_BITS = 6;
	// sampled pin bundle at the device
	typedef struct packed {
		logic style;
		logic force_en;
		logic wr_n;
		logic rd_n;
		logic [3:0] cs_n;
		logic [2:0] addr;
		logic [7:0] data;
	} dshp_pins_s;
	localparam dshp_pins_s PINS_IDLE = '{style: 1'b1, force_en: 1'b0, wr_n: 1'b1,
		rd_n: 1'b1, cs_n: 4'hf, addr: 3'h0, data: 8'hff};
	typedef enum logic [2:0] {
		DEV_IDLE = 3'b001,
		DEV_READ = 3'b010,
		DEV_WRITE = 3'b100
	} dshp_dev_state_e;
	typedef enum logic [3:0] {
		HST_IDLE = 4'b0001,
		HST_SETUP = 4'b0010,
		HST_STROBE = 4'b0100,
		HST_HOLD = 4'b1000
	} dshp_hst_state_e;
endpackage

// >>> include/dshp_bus_if.sv
interface dshp_bus_if;
	logic bus_style_sel;
	logic irq_force_enable;
	logic write_strobe_n;
	logic read_strobe_n;
	logic chan_a_select_n;
	logic chan_b_select_n;
	logic chan_c_select_n;
	logic chan_d_select_n;
	logic [2:0] reg_addr;
	logic [7:0] host_data;
	logic host_data_oe;
	logic [7:0] dev_data;
	logic dev_data_oe;
	logic [7:0] data;
	logic chan_a_irq, chan_b_irq, chan_c_irq, chan_d_irq;
	logic chan_a_irq_oe, chan_b_irq_oe, chan_c_irq_oe, chan_d_irq_oe;
	logic chan_a_irq_level, chan_b_irq_level, chan_c_irq_level, chan_d_irq_level;

	// data bus with a weak pull-up when nobody drives
	assign data = dev_data_oe ? dev_data : (host_data_oe ? host_data : 8'hff);
	// shared request is pulled up in rw style, floating pins read low otherwise
	assign chan_a_irq_level = chan_a_irq_oe ? chan_a_irq : ~bus_style_sel;
	assign chan_b_irq_level = chan_b_irq_oe ? chan_b_irq : 1'b0;
	assign chan_c_irq_level = chan_c_irq_oe ? chan_c_irq : 1'b0;
	assign chan_d_irq_level = chan_d_irq_oe ? chan_d_irq : 1'b0;

	modport device (
		input bus_style_sel, irq_force_enable, write_strobe_n, read_strobe_n,
		input chan_a_select_n, chan_b_select_n, chan_c_select_n, chan_d_select_n,
		input reg_addr, data,
		output dev_data, dev_data_oe,
		output chan_a_irq, chan_b_irq, chan_c_irq, chan_d_irq,
		output chan_a_irq_oe, chan_b_irq_oe, chan_c_irq_oe, chan_d_irq_oe
	);
	modport host (
		output bus_style_sel, irq_force_enable, write_strobe_n, read_strobe_n,
		output chan_a_select_n, chan_b_select_n, chan_c_select_n, chan_d_select_n,
		output reg_addr, host_data, host_data_oe,
		input data,
		input chan_a_irq_level, chan_b_irq_level, chan_c_irq_level, chan_d_irq_level
	);
endinterface

// >>> hw/dshp_device.sv
// Contract
// - strobe style: write strobe, capture on rise
// - rw style: write pin high read, low write
// - strobe style: four selects, one per channel
// - rw style: channel A select is chip select
// - rw style: selects B, C are channel address
// - rw style: select D ignored, host holds high
// - strobe style: interrupt floats unless bit 3 set
// - rw style: shared interrupt, open drain low
// - rw style: interrupts B, C, D held low
// - force pin high keeps interrupts enabled
// - host holds force pin low in rw style
// - build option ties force pin high or low
// - strobe style: read strobe, data driven until rise
// - three address bits pick channel register
module dshp_device
	import dshp_pkg::*;
#(
	parameter logic [1:0] IRQ_FORCE_MODE = FORCE_PIN
) (
	input wire logic pclk,
	input wire logic presetn,
	dshp_bus_if.device bus,
	input wire logic [3:0] chan_irq_req,
	output logic wr_event,
	output logic rd_event,
	output logic [1:0] event_chan,
	output logic [2:0] event_addr,
	output logic [7:0] event_data
);

	dshp_pins_s pin_raw;
	dshp_pins_s pin_meta;
	dshp_pins_s ps;
	dshp_dev_state_e state;
	logic active;
	logic is_read;
	logic [1:0] chan;
	logic [1:0] acc_chan;
	logic [2:0] acc_addr;
	logic [7:0] regs [4][8];
	logic force_eff;
	logic [3:0] irq_en;
	logic [3:0] irq_out;
	logic [3:0] irq_oe;
	logic [7:0] dout;
	logic dout_oe;

	// gather the pins; select D is carried even though rw style never reads it
	assign pin_raw.style = bus.bus_style_sel;
	assign pin_raw.force_en = bus.irq_force_enable;
	assign pin_raw.wr_n = bus.write_strobe_n;
	assign pin_raw.rd_n = bus.read_strobe_n;
	assign pin_raw.cs_n = {bus.chan_d_select_n, bus.chan_c_select_n,
		bus.chan_b_select_n, bus.chan_a_select_n};
	assign pin_raw.addr = bus.reg_addr;
	assign pin_raw.data = bus.data;

	// two-stage synchroniser; all fields share stages so they stay aligned
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta <= PINS_IDLE;
			ps <= PINS_IDLE;
		end else begin
			pin_meta <= pin_raw;
			ps <= pin_meta;
		end
	end

	// decode the access from the synced pins for the selected style
	always_comb begin
		active = 1'b0;
		is_read = 1'b0;
		chan = 2'h0;
		if (ps.style) begin
			active = (~ps.wr_n | ~ps.rd_n) & ~(&ps.cs_n);
			is_read = ~ps.rd_n;
			// several selects low at once: lowest channel wins
			if (!ps.cs_n[0]) begin
				chan = 2'h0;
			end else if (!ps.cs_n[1]) begin
				chan = 2'h1;
			end else if (!ps.cs_n[2]) begin
				chan = 2'h2;
			end else begin
				chan = 2'h3;
			end
		end else begin
			active = ~ps.cs_n[0];
			is_read = ps.wr_n;
			// select D never enters the decode
			chan = {ps.cs_n[2], ps.cs_n[1]};
		end
	end

	// access sequencer: begins on the falling strobe, ends on the rise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= DEV_IDLE;
		end else begin
			case (state)
				DEV_IDLE: begin
					if (active && is_read) begin
						state <= DEV_READ;
					end else if (active) begin
						state <= DEV_WRITE;
					end
				end
				DEV_READ, DEV_WRITE: begin
					if (!active) begin
						state <= DEV_IDLE;
					end
				end
				default: begin
					state <= DEV_IDLE;
				end
			endcase
		end
	end

	// channel and register address are frozen for the whole access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_chan <= 2'h0;
			acc_addr <= 3'h0;
		end else if (state == DEV_IDLE && active) begin
			acc_chan <= chan;
			acc_addr <= ps.addr;
		end
	end

	// register file; the byte seen with the rising strobe is the one stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int c = 0; c < 4; c++) begin
				for (int r = 0; r < 8; r++) begin
					regs[c][r] <= REG_RESET;
				end
			end
		end else if (state == DEV_WRITE && !active) begin
			regs[acc_chan][acc_addr] <= ps.data;
		end
	end

	// read data driven from the falling strobe until the rising strobe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dout <= 8'h00;
			dout_oe <= 1'b0;
		end else if (state == DEV_IDLE && active && is_read) begin
			dout <= regs[chan][ps.addr];
			dout_oe <= 1'b1;
		end else if (state == DEV_READ && !active) begin
			dout_oe <= 1'b0;
		end
	end

	assign bus.dev_data = dout;
	assign bus.dev_data_oe = dout_oe;

	// build option: follow the pin, or behave as if strapped high or low
	always_comb begin
		case (IRQ_FORCE_MODE)
			FORCE_HIGH: force_eff = 1'b1;
			FORCE_LOW: force_eff = 1'b0;
			default: force_eff = ps.force_en;
		endcase
	end

	// per-channel enable: force overrides the modem control bit
	always_comb begin
		for (int c = 0; c < 4; c++) begin
			irq_en[c] = force_eff | regs[c][MODEM_CTRL_OFS][IRQ_OUTPUT_ENABLE_BIT];
		end
	end

	// interrupt pins; registered so a pin never glitches on decode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_out <= 4'h0;
			irq_oe <= 4'h0;
		end else if (ps.style) begin
			irq_out <= chan_irq_req;
			irq_oe <= irq_en;
		end else begin
			// open drain: only ever pull low, never drive high
			irq_out <= 4'h0;
			irq_oe <= {3'b111, |chan_irq_req};
		end
	end

	assign bus.chan_a_irq = irq_out[0];
	assign bus.chan_b_irq = irq_out[1];
	assign bus.chan_c_irq = irq_out[2];
	assign bus.chan_d_irq = irq_out[3];
	assign bus.chan_a_irq_oe = irq_oe[0];
	assign bus.chan_b_irq_oe = irq_oe[1];
	assign bus.chan_c_irq_oe = irq_oe[2];
	assign bus.chan_d_irq_oe = irq_oe[3];

	// user-side report of each completed write and each started read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_event <= 1'b0;
			rd_event <= 1'b0;
			event_chan <= 2'h0;
			event_addr <= 3'h0;
			event_data <= 8'h00;
		end else begin
			wr_event <= (state == DEV_WRITE) && !active;
			rd_event <= (state == DEV_IDLE) && active && is_read;
			if (state == DEV_WRITE && !active) begin
				event_chan <= acc_chan;
				event_addr <= acc_addr;
				event_data <= ps.data;
			end else if (state == DEV_IDLE && active && is_read) begin
				event_chan <= chan;
				event_addr <= ps.addr;
				event_data <= regs[chan][ps.addr];
			end
		end
	end

endmodule // dshp_device

// >>> hw/dshp_host.sv
// Implementation choices: register access over APB and the placing of the registers.
module dshp_host
	import dshp_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	dshp_bus_if.host bus,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq
);

	dshp_hst_state_e state;
	logic [3:0] cnt;
	logic cfg_style;
	logic cfg_force;
	logic op_read;
	logic [2:0] op_addr;
	logic [1:0] op_chan;
	logic [7:0] op_wdata;
	logic [7:0] rdata;
	logic [IRQ_BITS-1:0] irq_stat;
	logic [IRQ_BITS-1:0] irq_en;
	logic [IRQ_BITS-1:0] irq_set;
	logic [IRQ_BITS-1:0] irq_clr;
	logic [11:0] in_meta;
	logic [11:0] in_sync;
	logic [3:0] lvl;
	logic [3:0] hit;
	logic wr_acc;
	logic start;
	logic done;
	logic [31:0] rmux;
	logic mapped;

	// one wait state: pready rises in the second access cycle
	assign wr_acc = psel & penable & pready & pwrite;
	assign start = wr_acc && paddr == CMD_OFS && pwdata[CMD_START_BIT];
	assign done = state == HST_HOLD && cnt == 4'(HOLD_CYC - 1);

	// read mux and address decode
	always_comb begin
		rmux = 32'h0;
		mapped = 1'b1;
		if (paddr == CMD_OFS) begin
			rmux = {16'h0, op_wdata, 1'b0, op_chan, op_addr, op_read, 1'b0};
		end else if (paddr == STATUS_OFS) begin
			rmux = {16'h0, rdata, 7'h0, state != HST_IDLE};
		end else if (paddr == CONFIG_OFS) begin
			rmux = {30'h0, cfg_force, cfg_style};
		end else if (paddr == IRQ_STATUS_OFS) begin
			rmux = {26'h0, irq_stat};
		end else if (paddr == IRQ_ENABLE_OFS) begin
			rmux = {26'h0, irq_en};
		end else if (paddr == IRQ_CLEAR_OFS) begin
			rmux = 32'h0;
		end else begin
			mapped = 1'b0;
		end
	end

	// apb answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~mapped;
			prdata <= rmux;
		end
	end

	// configuration and command latch; a start while busy is refused
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_style <= CFG_STYLE_RESET;
			cfg_force <= 1'b0;
			irq_en <= '0;
			op_read <= 1'b0;
			op_addr <= 3'h0;
			op_chan <= 2'h0;
			op_wdata <= 8'h00;
		end else begin
			if (wr_acc && paddr == CONFIG_OFS) begin
				cfg_style <= pwdata[CFG_STYLE_BIT];
				cfg_force <= pwdata[CFG_FORCE_BIT];
			end
			if (wr_acc && paddr == IRQ_ENABLE_OFS) begin
				irq_en <= pwdata[IRQ_BITS-1:0];
			end
			if (start && state == HST_IDLE) begin
				op_read <= pwdata[CMD_READ_BIT];
				op_addr <= pwdata[CMD_ADDR_LSB +: 3];
				op_chan <= pwdata[CMD_CHAN_LSB +: 2];
				op_wdata <= pwdata[CMD_DATA_LSB +: 8];
			end
		end
	end

	// transfer sequencer: setup, strobe, hold
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= HST_IDLE;
			cnt <= 4'h0;
		end else begin
			cnt <= cnt + 4'h1;
			case (state)
				HST_IDLE: begin
					cnt <= 4'h0;
					if (start) begin
						state <= HST_SETUP;
					end
				end
				HST_SETUP: begin
					if (cnt == 4'(SETUP_CYC - 1)) begin
						state <= HST_STROBE;
						cnt <= 4'h0;
					end
				end
				HST_STROBE: begin
					if (cnt == 4'(STROBE_CYC - 1)) begin
						state <= HST_HOLD;
						cnt <= 4'h0;
					end
				end
				HST_HOLD: begin
					if (done) begin
						state <= HST_IDLE;
						cnt <= 4'h0;
					end
				end
				default: begin
					state <= HST_IDLE;
				end
			endcase
		end
	end

	// pins lag the state by one cycle; every pin lags alike
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus.bus_style_sel <= CFG_STYLE_RESET;
			bus.irq_force_enable <= 1'b0;
			bus.write_strobe_n <= 1'b1;
			bus.read_strobe_n <= 1'b1;
			{bus.chan_d_select_n, bus.chan_c_select_n} <= 2'b11;
			{bus.chan_b_select_n, bus.chan_a_select_n} <= 2'b11;
			bus.reg_addr <= 3'h0;
			bus.host_data <= 8'h00;
			bus.host_data_oe <= 1'b0;
		end else begin
			bus.bus_style_sel <= cfg_style;
			bus.irq_force_enable <= cfg_style & cfg_force;
			bus.reg_addr <= op_addr;
			bus.host_data <= op_wdata;
			bus.host_data_oe <= state != HST_IDLE && !op_read;
			if (cfg_style) begin
				bus.write_strobe_n <= ~(state == HST_STROBE && !op_read);
				bus.read_strobe_n <= ~(state == HST_STROBE && op_read);
				{bus.chan_d_select_n, bus.chan_c_select_n, bus.chan_b_select_n,
					bus.chan_a_select_n} <= state == HST_IDLE ? 4'hf : ~(4'h1 << op_chan);
			end else begin
				bus.write_strobe_n <= op_read;
				bus.read_strobe_n <= 1'b1;
				bus.chan_a_select_n <= state != HST_STROBE;
				bus.chan_b_select_n <= op_chan[0];
				bus.chan_c_select_n <= op_chan[1];
				bus.chan_d_select_n <= 1'b1;
			end
		end
	end

	// synchronise the data bus and interrupt levels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_meta <= 12'h0ff;
			in_sync <= 12'h0ff;
		end else begin
			in_meta <= {bus.chan_d_irq_level, bus.chan_c_irq_level,
				bus.chan_b_irq_level, bus.chan_a_irq_level, bus.data};
			in_sync <= in_meta;
		end
	end

	// sample read data in the last strobe cycle, before the rise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata <= 8'h00;
		end else if (state == HST_STROBE && cnt == 4'(STROBE_CYC - 1) && op_read) begin
			rdata <= in_sync[7:0];
		end
	end

	// rw style has one active-low request, reported on channel A
	assign lvl = in_sync[11:8];
	assign hit = cfg_style ? lvl : {3'b000, ~lvl[0]};
	assign irq_set = {start && state != HST_IDLE, hit, done};
	assign irq_clr = (wr_acc && paddr == IRQ_CLEAR_OFS) ? pwdata[IRQ_BITS-1:0] : '0;

	// sticky status: a set in the clearing cycle survives
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat <= '0;
			irq <= 1'b0;
		end else begin
			irq_stat <= (irq_stat & ~irq_clr) | irq_set;
			irq <= |(((irq_stat & ~irq_clr) | irq_set) & irq_en);
		end
	end

endmodule // dshp_host

// >>> dv/dshp_assertions.sv
module dshp_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic bus_style_sel,
	input wire logic irq_force_enable,
	input wire logic write_strobe_n,
	input wire logic read_strobe_n,
	input wire logic chan_a_select_n,
	input wire logic chan_b_select_n,
	input wire logic chan_c_select_n,
	input wire logic chan_d_select_n,
	input wire logic [2:0] reg_addr,
	input wire logic dev_data_oe,
	input wire logic chan_a_irq,
	input wire logic chan_b_irq,
	input wire logic chan_c_irq,
	input wire logic chan_d_irq,
	input wire logic chan_a_irq_oe,
	input wire logic chan_b_irq_oe,
	input wire logic chan_c_irq_oe,
	input wire logic chan_d_irq_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// a read keeps address and selects steady for the first eight cycles of its strobe
	sequence rd_held_s;
		(!read_strobe_n && $stable(reg_addr) && $stable({chan_d_select_n, chan_c_select_n,
			chan_b_select_n, chan_a_select_n}))[*8];
	endsequence
	sequence rd_answer_s;
		##[1:8] (dev_data_oe && !read_strobe_n);
	endsequence
	// device interrupt pins follow a style pin change three edges later (two sync stages)
	sequence rw_steady_s;
		!bus_style_sel && $past(!bus_style_sel) && $past(!bus_style_sel, 2) &&
			$past(!bus_style_sel, 3);
	endsequence
	sequence force_steady_s;
		bus_style_sel && irq_force_enable && $past(bus_style_sel && irq_force_enable) &&
			$past(bus_style_sel && irq_force_enable, 2) &&
			$past(bus_style_sel && irq_force_enable, 3);
	endsequence

	rd_hold_a: assert property ($fell(read_strobe_n) && bus_style_sel |-> rd_held_s)
		else $error("read address moved during strobe");
	rd_answer_a: assert property ($fell(read_strobe_n) && bus_style_sel |-> rd_answer_s)
		else $error("read data not driven during strobe");
	one_select_a: assert property (bus_style_sel && !(read_strobe_n && write_strobe_n) |->
		$onehot({chan_d_select_n, chan_c_select_n, chan_b_select_n, chan_a_select_n} ^ 4'hf))
		else $error("not exactly one channel selected");
	one_strobe_a: assert property (bus_style_sel |-> read_strobe_n || write_strobe_n)
		else $error("both strobes low");
	wr_no_drive_a: assert property (bus_style_sel && !write_strobe_n |-> !dev_data_oe)
		else $error("device drives data during write");
	rw_read_dir_a: assert property (!bus_style_sel && $rose(dev_data_oe) |->
		write_strobe_n && !chan_a_select_n)
		else $error("rw style read without read direction");
	rw_pins_a: assert property (!bus_style_sel |-> !irq_force_enable && chan_d_select_n)
		else $error("force or select d not idle in rw style");
	rw_irq_od_a: assert property (rw_steady_s |-> !(chan_a_irq_oe && chan_a_irq))
		else $error("shared request driven high");
	rw_irq_zero_a: assert property (rw_steady_s |-> chan_b_irq_oe && chan_c_irq_oe &&
		chan_d_irq_oe && !(chan_b_irq || chan_c_irq || chan_d_irq))
		else $error("unused requests not held low");
	force_on_a: assert property (force_steady_s |->
		chan_a_irq_oe && chan_b_irq_oe && chan_c_irq_oe && chan_d_irq_oe)
		else $error("forced interrupt output not enabled");
endmodule // dshp_assertions

// >>> dv/dshp_tb_top.sv
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
	$display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module dshp_tb_top
	import dshp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [3:0] req;
	logic wr_event, rd_event;
	logic [1:0] event_chan;
	logic [2:0] event_addr;
	logic [7:0] event_data, got;
	int err_count = 0, check_count = 0;
	int wr_seen = 0, rd_seen = 0;
	dshp_bus_if bus_a();
	dshp_bus_if bus_b();
	dshp_bus_if bus_c();
	dshp_host dshp_host_inst(.pclk, .presetn, .bus(bus_a), .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .irq);
	dshp_device dshp_device_inst(.pclk, .presetn, .bus(bus_a), .chan_irq_req(req), .wr_event,
		.rd_event, .event_chan, .event_addr, .event_data);
	// tied-high build on an idle second link, only its interrupt pins are watched
	dshp_device #(.IRQ_FORCE_MODE(FORCE_HIGH)) dshp_device_tied_inst(.pclk, .presetn,
		.bus(bus_b), .chan_irq_req(req), .wr_event(), .rd_event(), .event_chan(),
		.event_addr(), .event_data());
	// tied-low build: its force pin is held high, yet bit 3 alone must rule
	dshp_device #(.IRQ_FORCE_MODE(FORCE_LOW)) dshp_device_low_inst(.pclk, .presetn,
		.bus(bus_c), .chan_irq_req(req), .wr_event(), .rd_event(), .event_chan(),
		.event_addr(), .event_data());
	dshp_assertions dshp_assertions_inst(.pclk(pclk), .presetn(presetn),
		.bus_style_sel(bus_a.bus_style_sel), .irq_force_enable(bus_a.irq_force_enable),
		.write_strobe_n(bus_a.write_strobe_n), .read_strobe_n(bus_a.read_strobe_n),
		.chan_a_select_n(bus_a.chan_a_select_n), .chan_b_select_n(bus_a.chan_b_select_n),
		.chan_c_select_n(bus_a.chan_c_select_n), .chan_d_select_n(bus_a.chan_d_select_n),
		.reg_addr(bus_a.reg_addr), .dev_data_oe(bus_a.dev_data_oe),
		.chan_a_irq(bus_a.chan_a_irq), .chan_b_irq(bus_a.chan_b_irq),
		.chan_c_irq(bus_a.chan_c_irq), .chan_d_irq(bus_a.chan_d_irq),
		.chan_a_irq_oe(bus_a.chan_a_irq_oe), .chan_b_irq_oe(bus_a.chan_b_irq_oe),
		.chan_c_irq_oe(bus_a.chan_c_irq_oe), .chan_d_irq_oe(bus_a.chan_d_irq_oe));

	// free-running 100 MHz clock
	always #5 pclk = ~pclk;

	// event pulses stand one cycle, so they are counted rather than polled
	always @(posedge pclk) begin
		wr_seen <= wr_seen + int'(wr_event === 1'b1);
		rd_seen <= rd_seen + int'(rd_event === 1'b1);
	end

	task report_and_stop;
		$display("mismatches %0d comparisons %0d", err_count, check_count);
		if (err_count == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task timed_out;
		err_count++;
		report_and_stop;
	endtask
	// one apb transfer, held until pready is seen with the access phase
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rq,
		output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= wr; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// read right after the edge, before its updates land: the value the slave saw
		for (n = 0; n < 50; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (n == 50) timed_out;
		rq = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] rq;
		logic e;
		apb(1'b1, a, d, rq, e);
	endtask
	task rd(input logic [11:0] a, output logic [31:0] rq);
		logic e;
		apb(1'b0, a, 32'h0, rq, e);
	endtask
	// one byte transfer on the link, waits for the host to go idle
	task xfer(input logic rdop, input logic [1:0] ch, input logic [2:0] ad, input logic [7:0] d);
		int n;
		wr(CMD_OFS, (32'(d) << CMD_DATA_LSB) | (32'(ch) << CMD_CHAN_LSB) |
			(32'(ad) << CMD_ADDR_LSB) | (32'(rdop) << CMD_READ_BIT) | 32'h1);
		for (n = 0; n < 40; n++) begin
			rd(STATUS_OFS, q);
			if (q[0] === 1'b0) break;
		end
		if (n == 40) timed_out;
		got = q[15:8];
	endtask
	// host pin lag, two device sync stages and the registered pin all have to pass
	task settle;
		repeat (6) @(negedge pclk);
	endtask
	task s_reset;
		rd(CONFIG_OFS, q);
		`CHK(q[CFG_STYLE_BIT], CFG_STYLE_RESET)
		req <= 4'hf;
		settle;
		`CHK({bus_a.chan_d_irq_level, bus_a.chan_c_irq_level, bus_a.chan_b_irq_level}, 3'h0)
		`CHK({bus_b.chan_d_irq_level, bus_b.chan_c_irq_level, bus_b.chan_b_irq_level}, 3'h7)
		`CHK({bus_c.chan_d_irq_level, bus_c.chan_c_irq_level, bus_c.chan_b_irq_level}, 3'h0)
		xfer(1'b1, 2'd2, MODEM_CTRL_OFS, 8'h00);
		`CHK(got, REG_RESET)
	endtask
	// distinct bytes per channel prove the selects are independent
	task s_channels(input logic style);
		int seen;
		wr(CONFIG_OFS, 32'(style));
		for (int c = 0; c < 4; c++) begin
			seen = wr_seen;
			xfer(1'b0, 2'(c), 3'(c + 1), 8'h30 + 8'(c) + (style ? 8'h00 : 8'h80));
			`CHK(wr_seen, seen + 1)
			`CHK(event_chan, 2'(c))
			`CHK(event_addr, 3'(c + 1))
			`CHK(event_data, 8'h30 + 8'(c) + (style ? 8'h00 : 8'h80))
		end
		// read back in strobe style so both decodes must agree
		wr(CONFIG_OFS, 32'h1);
		for (int c = 0; c < 4; c++) begin
			seen = rd_seen;
			xfer(1'b1, 2'(c), 3'(c + 1), 8'h00);
			`CHK(rd_seen, seen + 1)
			`CHK(got, 8'h30 + 8'(c) + (style ? 8'h00 : 8'h80))
		end
	endtask
	task s_irq_strobe;
		xfer(1'b0, 2'd1, MODEM_CTRL_OFS, 8'h08);
		req <= 4'h6;
		settle;
		`CHK({bus_a.chan_c_irq_level, bus_a.chan_b_irq_level}, 2'b01)
		@(posedge pclk);
		req <= 4'h4;
		settle;
		`CHK(bus_a.chan_b_irq_oe, 1'b1)
		`CHK(bus_a.chan_b_irq_level, 1'b0)
		wr(CONFIG_OFS, 32'h3);
		settle;
		`CHK(bus_a.chan_c_irq_level, 1'b1)
		wr(IRQ_ENABLE_OFS, 32'h8);
		settle;
		`CHK(irq, 1'b1)
		wr(IRQ_ENABLE_OFS, 32'h0);
		settle;
		`CHK(irq, 1'b0)
		req <= 4'h0;
		settle;
		wr(IRQ_CLEAR_OFS, 32'h3f);
		rd(IRQ_STATUS_OFS, q);
		`CHK(q[4:1], 4'h0)
	endtask
	task s_irq_rw;
		wr(CONFIG_OFS, 32'h2);
		settle;
		`CHK(bus_a.irq_force_enable, 1'b0)
		`CHK(bus_a.chan_a_irq_level, 1'b1)
		`CHK({bus_a.chan_d_irq_oe, bus_a.chan_c_irq_oe, bus_a.chan_b_irq_oe}, 3'h7)
		`CHK({bus_a.chan_d_irq, bus_a.chan_c_irq, bus_a.chan_b_irq}, 3'h0)
		// the style switch itself may flag the shared request, so start clean
		wr(IRQ_CLEAR_OFS, 32'h3f);
		rd(IRQ_STATUS_OFS, q);
		`CHK(q[IRQ_CHAN_LSB], 1'b0)
		@(posedge pclk);
		req <= 4'h2;
		settle;
		`CHK(bus_a.chan_a_irq_level, 1'b0)
		rd(IRQ_STATUS_OFS, q);
		`CHK(q[IRQ_CHAN_LSB], 1'b1)
		req <= 4'h0;
		// second start while busy is refused and flagged
		wr(CMD_OFS, 32'h1);
		xfer(1'b0, 2'd3, 3'h0, 8'h11);
		rd(IRQ_STATUS_OFS, q);
		`CHK(q[IRQ_REFUSED_BIT], 1'b1)
		// a read in this style: direction pin high, channel from the two address pins
		xfer(1'b1, 2'd2, 3'h3, 8'h00);
		`CHK(got, 8'hb2)
		apb(1'b0, 12'hffc, 32'h0, q, got[0]);
		`CHK({got[0], q}, {1'b1, 32'h0})
	endtask

	// stimulus, all inputs given a value at time zero
	initial begin
		psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0; req = 4'h0;
		bus_b.bus_style_sel = 1'b1; bus_b.irq_force_enable = 1'b0; bus_b.write_strobe_n = 1'b1;
		bus_b.read_strobe_n = 1'b1; bus_b.chan_a_select_n = 1'b1; bus_b.chan_b_select_n = 1'b1;
		bus_b.chan_c_select_n = 1'b1; bus_b.chan_d_select_n = 1'b1; bus_b.reg_addr = 3'h0;
		bus_b.host_data = 8'h00; bus_b.host_data_oe = 1'b0;
		bus_c.bus_style_sel = 1'b1;
		bus_c.irq_force_enable = 1'b1;
		bus_c.write_strobe_n = 1'b1;
		bus_c.read_strobe_n = 1'b1;
		bus_c.chan_a_select_n = 1'b1;
		bus_c.chan_b_select_n = 1'b1;
		bus_c.chan_c_select_n = 1'b1;
		bus_c.chan_d_select_n = 1'b1;
		bus_c.reg_addr = 3'h0;
		bus_c.host_data = 8'h00;
		bus_c.host_data_oe = 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		s_reset;
		s_channels(1'b1);
		s_channels(1'b0);
		s_irq_strobe;
		s_irq_rw;
		report_and_stop;
	end
endmodule // dshp_tb_top
